// File: core/sccr_top.sv
`timescale 1ns/1ps
// What this block does
// R1 - revision register reads interface code 10, zeros, fixed revision
// R2 - status bit 7 is inverted supply-valid pin
// R3 - status bit 5 is live ready/irq pin
// R4 - status bit 4 is live write-protect pin
// R5 - status bits 3:2 are inverted card-detect pins
// R6 - status bits 1:0 are raw battery detect pins
// R7 - software reads bit 0 as status change in io mode
// R8 - card power on needs power-good, vcc bit, auto-power condition
// R9 - one supply switch low when powered, chosen by 3.3v select
// R10 - auto-power makes power follow card insertion
// R11 - programming voltage field drives 12v or card supply switch
// R12 - socket outputs enabled by power-good, insertion and card enable
// R13 - card irq select routes card interrupt to one host irq
// R14 - redirect bit moves management interrupts to dedicated line
// R15 - io mode bit selects dual-function pin role
// R16 - card reset bit drives reset, polarity by disk mode, floats when disabled
// R17 - ring indicate drives irq15 in io mode with ring-out control
// R18 - control registers clear when power-good cycles
// R19 - index at 03e0, data at 03e1
// R20 - writes to read-only registers are ignored
module sccr_top
    import sccr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_oe,
    input wire logic device_sel,
    input wire logic supply_good_in,
    input wire logic prog_valid_n,
    input wire logic card_ready_irq,
    input wire logic write_protect_io16,
    input wire logic card_detect_a_n,
    input wire logic card_detect_b_n,
    input wire logic battery1_status_change,
    input wire logic battery2_speaker,
    input wire logic vcc_3v3_select,
    input wire logic disk_mode,
    input wire logic irq15_ring_out,
    input wire logic mgmt_irq_req,
    input wire logic [3:0] mgmt_irq_select,
    output logic io_card_mode,
    output logic socket_out_en,
    output logic vcc_3v3_switch_n,
    output logic vcc_5v_switch_n,
    output logic prog_12v_switch,
    output logic prog_card_supply_switch,
    output logic card_reset_out,
    output logic card_reset_oe,
    output logic host_mgmt_n_a,
    output logic [15:0] host_irq
);
    sccr_ctrl_if ctrl ();
    logic [7:0] index_q;
    logic [7:0] index_d;
    logic [7:0] power_q;
    logic [7:0] power_d;
    logic [7:0] intgen_q;
    logic [7:0] intgen_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rd_oe_q;
    logic rd_oe_d;
    logic good_q;
    logic card_power_on;
    logic hit_index;
    logic hit_data;
    logic socket_sel;

    assign hit_index = (io_addr == SCCR_INDEX_ADDR); // R19
    assign hit_data = (io_addr == SCCR_DATA_ADDR); // R19
    // only this device and socket a respond to the data port
    assign socket_sel = (index_q[SCCR_IDX_DEVICE_BIT] == device_sel)
        && !index_q[SCCR_IDX_SOCKET_BIT];

    // read multiplexer, live pins read straight through
    function automatic logic [7:0] reg_read(input logic [5:0] idx, input logic [7:0] st,
                                            input logic [7:0] pw, input logic [7:0] ig);
        logic [7:0] v;
        v = 8'h00;
        if (idx == SCCR_REG_REV) begin
            v = {SCCR_IFACE_MEM_IO, 2'h0, SCCR_REVISION};
        end else if (idx == SCCR_REG_STATUS) begin
            v = st;
        end else if (idx == SCCR_REG_POWER) begin
            v = pw;
        end else if (idx == SCCR_REG_INTGEN) begin
            v = ig;
        end
        return v;
    endfunction

    // next-state for index, control and read data
    always_comb begin
        logic [7:0] status;
        status = {!prog_valid_n, card_power_on, card_ready_irq, write_protect_io16,
                  !card_detect_b_n, !card_detect_a_n,
                  battery2_speaker, battery1_status_change}; // R2 R3 R4 R5 R6 R8
        index_d = index_q;
        power_d = power_q;
        intgen_d = intgen_q;
        rdata_d = rdata_q;
        rd_oe_d = 1'b0;
        if (!supply_good_in) begin
            power_d = SCCR_POWER_RST; // R18
            intgen_d = SCCR_INTGEN_RST; // R18
        end else if (io_wr && hit_index) begin
            index_d = io_wdata;
        end else if (io_wr && hit_data && socket_sel) begin
            // revision and status writes fall through untouched
            if (index_q[5:0] == SCCR_REG_POWER) begin
                power_d = io_wdata;
            end else if (index_q[5:0] == SCCR_REG_INTGEN) begin
                intgen_d = io_wdata;
            end // R20
        end
        if (io_rd && hit_index && !index_q[SCCR_IDX_DEVICE_BIT]) begin
            rdata_d = index_q;
            rd_oe_d = 1'b1;
        end else if (io_rd && hit_data && socket_sel) begin
            rdata_d = reg_read(index_q[5:0], status, power_q, intgen_q); // R1
            rd_oe_d = 1'b1;
        end
    end

    // registers; control bytes also clear while power-good is low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            index_q <= SCCR_INDEX_RST;
            power_q <= SCCR_POWER_RST;
            intgen_q <= SCCR_INTGEN_RST;
            rdata_q <= 8'h00;
            rd_oe_q <= 1'b0;
            good_q <= 1'b0;
        end else begin
            index_q <= index_d;
            power_q <= power_d;
            intgen_q <= intgen_d;
            rdata_q <= rdata_d;
            rd_oe_q <= rd_oe_d;
            good_q <= supply_good_in;
        end
    end

    assign ctrl.power_q = power_q;
    assign ctrl.intgen_q = intgen_q;
    assign io_rdata = rdata_q;
    assign io_rdata_oe = rd_oe_q;
    assign io_card_mode = intgen_q[SCCR_IG_IO_MODE]; // R15

    sccr_socket_drive u_drive (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ctrl(ctrl.sock),
        .supply_good_in(supply_good_in),
        .card_detect_a_n(card_detect_a_n),
        .card_detect_b_n(card_detect_b_n),
        .vcc_3v3_select(vcc_3v3_select),
        .disk_mode(disk_mode),
        .card_ready_irq(card_ready_irq),
        .battery1_status_change(battery1_status_change),
        .irq15_ring_out(irq15_ring_out),
        .mgmt_irq_req(mgmt_irq_req),
        .mgmt_irq_select(mgmt_irq_select),
        .card_power_on(card_power_on),
        .socket_out_en(socket_out_en),
        .vcc_3v3_switch_n(vcc_3v3_switch_n),
        .vcc_5v_switch_n(vcc_5v_switch_n),
        .prog_12v_switch(prog_12v_switch),
        .prog_card_supply_switch(prog_card_supply_switch),
        .card_reset_out(card_reset_out),
        .card_reset_oe(card_reset_oe),
        .host_mgmt_n_a(host_mgmt_n_a),
        .host_irq(host_irq)
    );

    chk_power_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(good_q) |-> (power_q == 8'h00 && intgen_q == 8'h00)) // R18
        else $error("control not cleared on power-good loss");
    chk_power_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (supply_good_in && io_wr && hit_data && socket_sel && index_q[5:0] == 6'h02)
        |=> power_q == $past(io_wdata)) // R19
        else $error("power control write lost");
    chk_status_ro: assert property (@(posedge core_clk) disable iff (!rst_n)
        (io_wr && hit_data && index_q[5:0] == 6'h01) |=> $stable(power_q) || !good_q) // R20
        else $error("status write touched control");
    chk_rev_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (io_rd && hit_data && socket_sel && index_q[5:0] == 6'h00)
        |=> io_rdata_oe && io_rdata[7:4] == 4'h8) // R1
        else $error("revision read wrong");
    chk_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (io_rd && hit_data && socket_sel && index_q[5:0] == 6'h01)
        |=> io_rdata[3:2] == ~$past({card_detect_b_n, card_detect_a_n})
            && io_rdata[7] == !$past(prog_valid_n)) // R2 R5
        else $error("status read wrong");
    chk_out_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
        socket_out_en |-> supply_good_in && !card_detect_a_n && !card_detect_b_n
            && power_q[7]) // R12
        else $error("socket outputs enabled wrongly");
    chk_power_on: assert property (@(posedge core_clk) disable iff (!rst_n)
        (power_q[4] && power_q[5] && card_detect_a_n && supply_good_in)
        |-> vcc_3v3_switch_n && vcc_5v_switch_n) // R10
        else $error("auto-power without card");
    chk_reset_float: assert property (@(posedge core_clk) disable iff (!rst_n)
        !power_q[7] |-> !card_reset_oe) // R16
        else $error("reset driven with card disabled");
endmodule // sccr_top

// File: core/sccr_pkg.sv
package sccr_pkg;
    // host-side port addresses of the index/data pair
    localparam logic [15:0] SCCR_INDEX_ADDR = 16'h03E0;
    localparam logic [15:0] SCCR_DATA_ADDR = 16'h03E1;
    // register indexes within a socket
    localparam logic [5:0] SCCR_REG_REV = 6'h00;
    localparam logic [5:0] SCCR_REG_STATUS = 6'h01;
    localparam logic [5:0] SCCR_REG_POWER = 6'h02;
    localparam logic [5:0] SCCR_REG_INTGEN = 6'h03;
    // index register fields
    localparam int SCCR_IDX_DEVICE_BIT = 7;
    localparam int SCCR_IDX_SOCKET_BIT = 6;
    // revision register contents
    localparam logic [1:0] SCCR_IFACE_MEM_IO = 2'h2;
    localparam logic [3:0] SCCR_REVISION = 4'h1; // arbitrary value
    // power control fields
    localparam int SCCR_PWR_CARD_EN = 7;
    localparam int SCCR_PWR_AUTO = 5;
    localparam int SCCR_PWR_VCC = 4;
    // interrupt/general control fields
    localparam int SCCR_IG_RING_EN = 7;
    localparam int SCCR_IG_RESET_N = 6;
    localparam int SCCR_IG_IO_MODE = 5;
    localparam int SCCR_IG_MGMT_REDIR = 4;
    // reset values
    localparam logic [7:0] SCCR_POWER_RST = 8'h00;
    localparam logic [7:0] SCCR_INTGEN_RST = 8'h00;
    localparam logic [7:0] SCCR_INDEX_RST = 8'h00;
    // programming-voltage codes
    localparam logic [1:0] SCCR_VPP_CARD = 2'h1;
    localparam logic [1:0] SCCR_VPP_12V = 2'h2;
endpackage

// File: core/sccr_ctrl_if.sv
`timescale 1ns/1ps
// control fields handed from the register file to the socket logic
interface sccr_ctrl_if;
    logic [7:0] power_q;
    logic [7:0] intgen_q;
    modport regs (output power_q, output intgen_q);
    modport sock (input power_q, input intgen_q);
endinterface

// File: core/sccr_socket_drive.sv
`timescale 1ns/1ps
// socket-facing decode of supply, output enables, reset and irq routing
module sccr_socket_drive
    import sccr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    sccr_ctrl_if.sock ctrl,
    input wire logic supply_good_in,
    input wire logic card_detect_a_n,
    input wire logic card_detect_b_n,
    input wire logic vcc_3v3_select,
    input wire logic disk_mode,
    input wire logic card_ready_irq,
    input wire logic battery1_status_change,
    input wire logic irq15_ring_out,
    input wire logic mgmt_irq_req,
    input wire logic [3:0] mgmt_irq_select,
    output logic card_power_on,
    output logic socket_out_en,
    output logic vcc_3v3_switch_n,
    output logic vcc_5v_switch_n,
    output logic prog_12v_switch,
    output logic prog_card_supply_switch,
    output logic card_reset_out,
    output logic card_reset_oe,
    output logic host_mgmt_n_a,
    output logic [15:0] host_irq
);
    logic inserted;
    logic [15:0] irq_d;
    logic [15:0] irq_q;
    logic mgmt_n_d;
    logic mgmt_n_q;

    // one-hot host irq line for a 4-bit select, reserved codes give nothing
    function automatic logic [15:0] irq_line(input logic [3:0] sel);
        logic [15:0] v;
        v = 16'h0000;
        case (sel)
            4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF: v[sel] = 1'b1;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    assign inserted = !card_detect_a_n && !card_detect_b_n;

    // supply gating follows power-good, vcc bit and auto-power
    assign card_power_on = supply_good_in && ctrl.power_q[SCCR_PWR_VCC]
        && (!ctrl.power_q[SCCR_PWR_AUTO] || inserted); // R8 R10
    assign vcc_3v3_switch_n = !(card_power_on && vcc_3v3_select); // R9
    assign vcc_5v_switch_n = !(card_power_on && !vcc_3v3_select); // R9
    assign prog_card_supply_switch = card_power_on
        && (ctrl.power_q[1:0] == SCCR_VPP_CARD); // R11
    assign prog_12v_switch = card_power_on && (ctrl.power_q[1:0] == SCCR_VPP_12V); // R11

    // enable table wins over bit text: vcc power not required
    assign socket_out_en = supply_good_in && inserted && ctrl.power_q[SCCR_PWR_CARD_EN]; // R12
    assign card_reset_oe = socket_out_en; // R16
    assign card_reset_out = ctrl.intgen_q[SCCR_IG_RESET_N] ^ !disk_mode; // R16

    // irq routing, ring indicate onto irq15 only in io mode
    always_comb begin
        logic card_irq;
        logic ring;
        card_irq = ctrl.intgen_q[SCCR_IG_IO_MODE] && !card_ready_irq; // R15
        ring = ctrl.intgen_q[SCCR_IG_IO_MODE] && ctrl.intgen_q[SCCR_IG_RING_EN]
            && irq15_ring_out && !battery1_status_change; // R17
        irq_d = card_irq ? irq_line(ctrl.intgen_q[3:0]) : 16'h0000; // R13
        mgmt_n_d = 1'b1;
        if (mgmt_irq_req && ctrl.intgen_q[SCCR_IG_MGMT_REDIR]) begin
            mgmt_n_d = 1'b0; // R14
        end else if (mgmt_irq_req) begin
            irq_d = irq_d | irq_line(mgmt_irq_select);
        end
        irq_d[15] = irq_d[15] | ring;
    end

    // registered interrupt outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 16'h0000;
            mgmt_n_q <= 1'b1;
        end else begin
            irq_q <= irq_d;
            mgmt_n_q <= mgmt_n_d;
        end
    end
    assign host_irq = irq_q;
    assign host_mgmt_n_a = mgmt_n_q;

    chk_supply_exclusive: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(!vcc_3v3_switch_n && !vcc_5v_switch_n)) // R9
        else $error("both supply switches active");
    chk_vpp_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
        (prog_12v_switch || prog_card_supply_switch) |-> card_power_on) // R11
        else $error("vpp switch without card power");
    chk_mgmt_redirect: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mgmt_irq_req && ctrl.intgen_q[SCCR_IG_MGMT_REDIR]) |=> !host_mgmt_n_a) // R14
        else $error("redirected management irq missing");
endmodule // sccr_socket_drive

// File: tb/sccr_card_model.sv
`timescale 1ns/1ps
// behavioural pc card at the socket: detect contacts and status pins
module sccr_card_model (
    input wire logic det_a,
    input wire logic det_b,
    input wire logic ready,
    input wire logic wp,
    input wire logic bvd1,
    input wire logic bvd2,
    output logic card_detect_a_n,
    output logic card_detect_b_n,
    output logic card_ready_irq,
    output logic write_protect_io16,
    output logic battery1_status_change,
    output logic battery2_speaker
);
    logic seated;
    // a made contact grounds its detect pin, an open one floats to the pull-up
    assign card_detect_a_n = !det_a;
    assign card_detect_b_n = !det_b;
    // a card that is not fully seated drives nothing, so the pins sit at the pull-ups
    assign seated = det_a && det_b;
    assign card_ready_irq = seated ? ready : 1'b1;
    assign write_protect_io16 = seated ? wp : 1'b1;
    assign battery1_status_change = seated ? bvd1 : 1'b1;
    assign battery2_speaker = seated ? bvd2 : 1'b1;
endmodule // sccr_card_model

// File: tb/sccr_top_test.sv
`timescale 1ns/1ps
module sccr_top_test;
    import sccr_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic io_rd = 1'b0;
    logic io_wr = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic device_sel = 1'b0;
    logic supply_good_in = 1'b1;
    logic prog_valid_n = 1'b1;
    logic vcc_3v3_select = 1'b0;
    logic disk_mode = 1'b0;
    logic irq15_ring_out = 1'b0;
    logic mgmt_irq_req = 1'b0;
    logic [3:0] mgmt_irq_select = 4'h0;
    logic det_a = 1'b0, det_b = 1'b0, ready = 1'b0, wp = 1'b0, bvd1 = 1'b0, bvd2 = 1'b0;
    logic card_detect_a_n, card_detect_b_n, card_ready_irq, write_protect_io16;
    logic battery1_status_change, battery2_speaker;
    logic [7:0] io_rdata;
    logic io_rdata_oe, io_card_mode, socket_out_en, vcc_3v3_switch_n, vcc_5v_switch_n;
    logic prog_12v_switch, prog_card_supply_switch, card_reset_out, card_reset_oe;
    logic host_mgmt_n_a;
    logic [15:0] host_irq;
    int fail_count = 0;
    int check_count = 0;
    logic [31:0] seed = 32'hAA82;
    logic [7:0] q, pw, ig, r;
    logic oe, on, en;

    sccr_card_model card (.det_a(det_a), .det_b(det_b), .ready(ready), .wp(wp), .bvd1(bvd1),
        .bvd2(bvd2), .card_detect_a_n(card_detect_a_n), .card_detect_b_n(card_detect_b_n),
        .card_ready_irq(card_ready_irq), .write_protect_io16(write_protect_io16),
        .battery1_status_change(battery1_status_change), .battery2_speaker(battery2_speaker));

    sccr_top uut (.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd),
        .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe),
        .device_sel(device_sel), .supply_good_in(supply_good_in), .prog_valid_n(prog_valid_n),
        .card_ready_irq(card_ready_irq), .write_protect_io16(write_protect_io16),
        .card_detect_a_n(card_detect_a_n), .card_detect_b_n(card_detect_b_n),
        .battery1_status_change(battery1_status_change), .battery2_speaker(battery2_speaker),
        .vcc_3v3_select(vcc_3v3_select), .disk_mode(disk_mode), .irq15_ring_out(irq15_ring_out),
        .mgmt_irq_req(mgmt_irq_req), .mgmt_irq_select(mgmt_irq_select),
        .io_card_mode(io_card_mode), .socket_out_en(socket_out_en),
        .vcc_3v3_switch_n(vcc_3v3_switch_n), .vcc_5v_switch_n(vcc_5v_switch_n),
        .prog_12v_switch(prog_12v_switch), .prog_card_supply_switch(prog_card_supply_switch),
        .card_reset_out(card_reset_out), .card_reset_oe(card_reset_oe),
        .host_mgmt_n_a(host_mgmt_n_a), .host_irq(host_irq));

    // free-running core clock, 10 ns period
    always #5 core_clk = ~core_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // eight shifts per byte so successive bytes are not just shifted copies
    task automatic rnd(output logic [7:0] v);
        repeat (8) seed = lfsr(seed);
        v = seed[7:0];
    endtask

    // one host cycle: strobe from a falling edge, taken at the rising edge, result next fall
    task automatic io_cycle(input logic [15:0] a, input logic wr, input logic [7:0] d);
        @(negedge core_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = wr;
        io_rd = !wr;
        @(negedge core_clk);
        q = io_rdata;
        oe = io_rdata_oe;
        io_wr = 1'b0;
        io_rd = 1'b0;
    endtask

    task automatic reg_wr(input logic [5:0] idx, input logic [7:0] d);
        io_cycle(SCCR_INDEX_ADDR, 1'b1, {device_sel, 1'b0, idx});
        io_cycle(SCCR_DATA_ADDR, 1'b1, d);
    endtask

    task automatic reg_rd(input logic [5:0] idx);
        io_cycle(SCCR_INDEX_ADDR, 1'b1, {device_sel, 1'b0, idx});
        io_cycle(SCCR_DATA_ADDR, 1'b0, 8'h00);
    endtask

    function automatic logic [15:0] exp_irq(input logic [3:0] code);
        return (code inside {3, 4, 5, 7, 9, 10, 11, 12, 14, 15}) ? 16'h0001 << code : 16'h0000;
    endfunction

    task automatic irq_check(input logic [7:0] igv, input logic [15:0] exp, input logic mg);
        reg_wr(SCCR_REG_INTGEN, igv);
        repeat (2) @(negedge core_clk);
        check(host_irq, exp);
        check({15'h0000, host_mgmt_n_a}, {15'h0000, mg});
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog well beyond the roughly 700 cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        final_report();
    end

    initial begin
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        reg_rd(SCCR_REG_POWER);
        check(q, SCCR_POWER_RST);
        reg_rd(SCCR_REG_INTGEN);
        check(q, SCCR_INTGEN_RST);
        reg_wr(SCCR_REG_REV, 8'hFF);
        reg_wr(SCCR_REG_STATUS, 8'hFF);
        reg_rd(SCCR_REG_REV);
        check({7'h00, oe, q}, {7'h00, 1'b1, 2'h2, 2'h0, SCCR_REVISION});
        $display("test reset_and_readonly done");
        // random register and pin mix, pins changed only after the writes land
        for (int i = 0; i < 40; i++) begin
            rnd(pw);
            rnd(ig);
            rnd(r);
            reg_wr(SCCR_REG_POWER, pw);
            reg_wr(SCCR_REG_INTGEN, ig);
            @(negedge core_clk);
            {det_a, det_b, ready, wp, bvd1, bvd2, prog_valid_n, vcc_3v3_select} = r;
            disk_mode = pw[6];
            #1;
            on = pw[SCCR_PWR_VCC] && (!pw[SCCR_PWR_AUTO] || (det_a && det_b));
            en = det_a && det_b && pw[SCCR_PWR_CARD_EN];
            check(vcc_3v3_switch_n, !(on && vcc_3v3_select));
            check(vcc_5v_switch_n, !(on && !vcc_3v3_select));
            check(prog_12v_switch, on && pw[1:0] == SCCR_VPP_12V);
            check(prog_card_supply_switch, on && pw[1:0] == SCCR_VPP_CARD);
            check(socket_out_en, en);
            check(card_reset_oe, en);
            if (en) check(card_reset_out, !ig[SCCR_IG_RESET_N] ^ disk_mode);
            check(io_card_mode, ig[SCCR_IG_IO_MODE]);
            reg_rd(SCCR_REG_STATUS);
            check(q, {!prog_valid_n, on, card_ready_irq, write_protect_io16, !card_detect_b_n,
                !card_detect_a_n, battery2_speaker, battery1_status_change});
            if (ig[SCCR_IG_IO_MODE]) check(q[0], battery1_status_change);
        end
        $display("test random_power_status done");
        // power-good drop: supplies off at once, control registers cleared at the edge
        reg_wr(SCCR_REG_POWER, 8'h90);
        @(negedge core_clk);
        supply_good_in = 1'b0;
        #1;
        check({vcc_3v3_switch_n, vcc_5v_switch_n, socket_out_en}, 3'b110);
        @(negedge core_clk);
        supply_good_in = 1'b1;
        reg_rd(SCCR_REG_POWER);
        check(q, SCCR_POWER_RST);
        $display("test power_good_drop done");
        // seated card raising its request (low) in io mode, every select code
        @(negedge core_clk);
        {det_a, det_b, ready, bvd1} = 4'b1101;
        for (int c = 0; c < 16; c++) begin
            irq_check({4'h2, c[3:0]}, exp_irq(c[3:0]), 1'b1);
        end
        $display("test card_irq_routing done");
        @(negedge core_clk);
        mgmt_irq_req = 1'b1;
        mgmt_irq_select = 4'h5;
        irq_check(8'h30, 16'h0000, 1'b0);
        irq_check(8'h20, 16'h0020, 1'b1);
        @(negedge core_clk);
        mgmt_irq_req = 1'b0;
        irq15_ring_out = 1'b1;
        bvd1 = 1'b0;
        irq_check(8'hA0, 16'h8000, 1'b1);
        irq_check(8'h80, 16'h0000, 1'b1);
        $display("test mgmt_and_ring done");
        // other device index and a neighbouring port must not answer
        io_cycle(SCCR_INDEX_ADDR, 1'b1, {!device_sel, 1'b0, SCCR_REG_REV});
        io_cycle(SCCR_DATA_ADDR, 1'b0, 8'h00);
        check(oe, 1'b0);
        io_cycle(16'h03E2, 1'b0, 8'h00);
        check(oe, 1'b0);
        $display("test decode done");
        final_report();
    end
endmodule // sccr_top_test
